// ---- rtl/npi_pkg.sv ----
// constants shared by the nested priority interrupt controller
// Function
// (R1) five fixed priority levels, zero lowest
// (R2) three peripheral inputs, two external pins
// (R3) any interrupt outranks all scheduled processes
// (R4) one handler process per level
// (R5) pin, peripheral or software bit raises requests
// (R6) one workspace pointer per level, position sets priority
// (R7) core acknowledges request at once, calls handler
// (R8) high priority interrupt saves state in handler workspace
// (R9) idle or low priority saves null status, shadows
// (R10) interrupt return restores state and signals completion
// (R11) record executing priority until completion arrives
// (R12) block not-higher requests, forward higher ones
// (R13) handler restores workspace pointer before returning
// (R14) software prepares save area before writing pointer
// (R15) software keeps interrupts off during fast acquisition
// (R16) separate handler workspace per level
// (R17) three-bit trigger select per channel
// (R18) level trigger keeps requesting while input active
// (R19) pending flags kept, gated by enable mask
// (R20) mask resets zero; global bit sixteen plus channel bit
// (R21) edge pending cleared when core acknowledges it
// (R22) highest eligible channel above executing priority wins
package npi_pkg;

  localparam int NPI_LEVELS = 5;
  localparam int NPI_LVL_W = 3;

  // register byte offsets
  localparam logic [11:0] NPI_OFS_WPTR_BASE = 12'h000;
  localparam logic [11:0] NPI_OFS_TRIG_BASE = 12'h040;
  localparam logic [11:0] NPI_OFS_PENDING = 12'h080;
  localparam logic [11:0] NPI_OFS_SOFT_REQ = 12'h084;
  localparam logic [11:0] NPI_OFS_EXEC = 12'h088;
  localparam logic [11:0] NPI_OFS_MASK = 12'h0C0;
  localparam int NPI_ADDR_W = 12;

  // field positions
  localparam int NPI_GLOBAL_EN_BIT = 16;
  localparam int NPI_WPTR_LSB = 2;
  localparam int NPI_EXEC_LVL_LSB = 8;
  localparam int NPI_EXEC_BUSY_BIT = 12;

  // reset values
  localparam logic [31:0] NPI_MASK_RESET = 32'h0000_0000;
  localparam logic [29:0] NPI_WPTR_RESET = 30'h0000_0000;

  // sync stages for inputs from outside pclk
  localparam int NPI_SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    NPI_TRIG_NONE = 3'b000,
    NPI_TRIG_HIGH = 3'b001,
    NPI_TRIG_LOW = 3'b010,
    NPI_TRIG_RISE = 3'b011,
    NPI_TRIG_FALL = 3'b100,
    NPI_TRIG_ANY = 3'b101,
    NPI_TRIG_NONE6 = 3'b110,
    NPI_TRIG_NONE7 = 3'b111
  } npi_trig_t;

  typedef enum logic [0:0] {
    NPI_HS_IDLE = 1'b0,
    NPI_HS_REQ = 1'b1
  } npi_hs_t;

endpackage

// ---- rtl/npi_trigger.sv ----
// one channel's input conditioning, trigger detect and pending flag
`timescale 1ns/1ps
module npi_trigger #(
  parameter bit SYNC = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_in,
  input wire logic [2:0] trig_sel,
  input wire logic clr,
  output logic pending
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic val_q;
  logic prev_q;
  logic val;
  logic edge_q;
  logic level_hit;
  logic edge_hit;

  generate
    if (SYNC) begin : g_sync
      // three stages; a change counts when the last two agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          val_q <= 1'b0;
        end else begin
          s1_q <= src_in;
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            val_q <= s3_q;
          end
        end
      end
      assign val = val_q;
    end else begin : g_direct
      // same clock domain: no synchroniser
      assign s1_q = 1'b0;
      assign s2_q = 1'b0;
      assign s3_q = 1'b0;
      assign val_q = 1'b0;
      assign val = src_in;
    end
  endgenerate

  // previous value for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= val;
    end
  end

  // trigger decode
  always_comb begin
    level_hit = 1'b0;
    edge_hit = 1'b0;
    unique case (npi_pkg::npi_trig_t'(trig_sel)) // R17
      npi_pkg::NPI_TRIG_HIGH: level_hit = val;
      npi_pkg::NPI_TRIG_LOW: level_hit = ~val;
      npi_pkg::NPI_TRIG_RISE: edge_hit = val & ~prev_q;
      npi_pkg::NPI_TRIG_FALL: edge_hit = ~val & prev_q;
      npi_pkg::NPI_TRIG_ANY: edge_hit = val ^ prev_q;
      default: begin
        level_hit = 1'b0;
        edge_hit = 1'b0;
      end
    endcase
  end

  // sticky edge flag; a new edge wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_q <= 1'b0;
    end else if (edge_hit) begin
      edge_q <= 1'b1;
    end else if (clr) begin
      edge_q <= 1'b0; // R21
    end
  end

  // level stays pending while active
  assign pending = level_hit | edge_q; // R18

endmodule

// ---- rtl/npi_ctrl.sv ----
// nested priority interrupt controller with apb registers and core hand-off
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module npi_ctrl #(
  parameter int LEVELS = npi_pkg::NPI_LEVELS,
  parameter int PINS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] ext_irq_pin,
  input wire logic [LEVELS-PINS-1:0] periph_irq,
  output logic core_int_req,
  output logic [2:0] core_int_level,
  output logic [31:0] handler_workspace_ptr,
  input wire logic core_int_ack,
  input wire logic core_int_return,
  output logic [LEVELS-1:0] active_levels,
  output logic handler_busy
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [29:0] wptr_q [LEVELS];
  logic [2:0] trig_q [LEVELS];
  logic [LEVELS-1:0] channel_enable_bit_q;
  logic all_channels_enable_q;
  logic [LEVELS-1:0] soft_req_q;
  logic [LEVELS-1:0] active_q;
  logic [LEVELS-1:0] raw_src;
  logic [LEVELS-1:0] hw_pending;
  logic [LEVELS-1:0] pending;
  logic [LEVELS-1:0] eligible;
  logic [LEVELS-1:0] ack_clr;
  logic [2:0] exec_lvl;
  logic exec_busy;
  logic [2:0] best_lvl;
  logic best_found;
  logic [2:0] req_lvl_q;
  logic [31:0] req_ptr_q;
  npi_pkg::npi_hs_t hs_q;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic err_d;
  logic err_q;
  logic setup;
  logic wr_en;
  logic [LEVELS-1:0] ret_clr;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: setup phase decodes, access phase completes with no wait

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & ~err_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;
  assign prdata = prdata_q;

  // read data and address check, captured in the setup cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b1;
    for (int i = 0; i < LEVELS; i++) begin
      if (paddr == npi_pkg::NPI_OFS_WPTR_BASE + 12'(4 * i)) begin
        rdata_d = {wptr_q[i], 2'b00}; // R6
        err_d = 1'b0;
      end
      if (paddr == npi_pkg::NPI_OFS_TRIG_BASE + 12'(4 * i)) begin
        rdata_d = {29'h0000_0000, trig_q[i]};
        err_d = 1'b0;
      end
    end
    unique case (paddr)
      npi_pkg::NPI_OFS_MASK: begin
        rdata_d[LEVELS-1:0] = channel_enable_bit_q;
        rdata_d[npi_pkg::NPI_GLOBAL_EN_BIT] = all_channels_enable_q;
        err_d = 1'b0;
      end
      npi_pkg::NPI_OFS_PENDING: begin
        rdata_d[LEVELS-1:0] = pending; // R19
        err_d = 1'b0;
      end
      npi_pkg::NPI_OFS_SOFT_REQ: begin
        rdata_d[LEVELS-1:0] = soft_req_q;
        err_d = 1'b0;
      end
      npi_pkg::NPI_OFS_EXEC: begin
        rdata_d[LEVELS-1:0] = active_q;
        rdata_d[npi_pkg::NPI_EXEC_LVL_LSB +: 3] = exec_lvl;
        rdata_d[npi_pkg::NPI_EXEC_BUSY_BIT] = exec_busy;
        err_d = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // read data and error register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      err_q <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-level configuration registers

  generate
    for (genvar g = 0; g < LEVELS; g++) begin : g_cfg
      // vector table entry, low two bits read as zero
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wptr_q[g] <= npi_pkg::NPI_WPTR_RESET;
        end else if (wr_en && paddr == npi_pkg::NPI_OFS_WPTR_BASE + 12'(4 * g)) begin
          wptr_q[g] <= pwdata[31:npi_pkg::NPI_WPTR_LSB]; // R6 R16
        end
      end

      // trigger select
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          trig_q[g] <= npi_pkg::NPI_TRIG_NONE;
        end else if (wr_en && paddr == npi_pkg::NPI_OFS_TRIG_BASE + 12'(4 * g)) begin
          trig_q[g] <= pwdata[2:0]; // R17
        end
      end
    end
  endgenerate

  // enable mask: cleared at reset, global bit plus channel bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_bit_q <= npi_pkg::NPI_MASK_RESET[LEVELS-1:0]; // R20
      all_channels_enable_q <= npi_pkg::NPI_MASK_RESET[npi_pkg::NPI_GLOBAL_EN_BIT]; // R20
    end else if (wr_en && paddr == npi_pkg::NPI_OFS_MASK) begin
      channel_enable_bit_q <= pwdata[LEVELS-1:0];
      all_channels_enable_q <= pwdata[npi_pkg::NPI_GLOBAL_EN_BIT];
    end
  end

  // software request bits: write one sets, write zero clears,
  // acknowledge clears, a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_req_q <= '0;
    end else if (wr_en && paddr == npi_pkg::NPI_OFS_SOFT_REQ) begin
      soft_req_q <= pwdata[LEVELS-1:0] | (soft_req_q & ~ack_clr & pwdata[LEVELS-1:0]); // R5
    end else begin
      soft_req_q <= soft_req_q & ~ack_clr; // R21
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request sources and trigger detection

  // low channels from peripherals, top channels from pins
  assign raw_src = {ext_irq_pin, periph_irq}; // R2

  generate
    for (genvar c = 0; c < LEVELS; c++) begin : g_chan
      npi_trigger #(
        .SYNC(c >= LEVELS - PINS)
      ) u_trig (
        .pclk(pclk),
        .presetn(presetn),
        .src_in(raw_src[c]),
        .trig_sel(trig_q[c]),
        .clr(ack_clr[c]),
        .pending(hw_pending[c])
      );
    end
  endgenerate

  // pending stays visible whether masked or not
  assign pending = hw_pending | soft_req_q; // R5 R19
  assign eligible = pending & channel_enable_bit_q & {LEVELS{all_channels_enable_q}}; // R19 R20

  ////////////////////////////////////////////////////////////////////////
  // executing priority record and selection

  // highest active level is the executing priority
  always_comb begin
    exec_lvl = 3'h0;
    exec_busy = 1'b0;
    for (int i = 0; i < LEVELS; i++) begin
      if (active_q[i]) begin
        exec_lvl = 3'(i); // R11
        exec_busy = 1'b1;
      end
    end
  end

  // highest eligible level above the executing one
  always_comb begin
    best_lvl = 3'h0;
    best_found = 1'b0;
    for (int i = 0; i < LEVELS; i++) begin
      if (eligible[i] && (!exec_busy || 3'(i) > exec_lvl)) begin // R12
        best_lvl = 3'(i); // R1 R22
        best_found = 1'b1;
      end
    end
  end

  // one-hot of the acknowledged level
  always_comb begin
    ack_clr = '0;
    if (hs_q == npi_pkg::NPI_HS_REQ && core_int_ack) begin
      ack_clr[req_lvl_q] = 1'b1; // R21
    end
  end

  // completion removes the most recent, highest active level
  always_comb begin
    ret_clr = '0;
    if (core_int_return && exec_busy) begin
      ret_clr[exec_lvl] = 1'b1; // R10
    end
  end

  // nesting record: set on acknowledge, cleared only on return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= '0;
    end else begin
      active_q <= (active_q & ~ret_clr) | ack_clr; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core hand-off: request held until the core acknowledges it

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q <= npi_pkg::NPI_HS_IDLE;
      req_lvl_q <= 3'h0;
      req_ptr_q <= 32'h0000_0000;
    end else begin
      unique case (hs_q)
        npi_pkg::NPI_HS_IDLE: begin
          if (best_found) begin
            hs_q <= npi_pkg::NPI_HS_REQ; // R3 R12
            req_lvl_q <= best_lvl;
            req_ptr_q <= {wptr_q[best_lvl], 2'b00}; // R4 R6
          end
        end
        npi_pkg::NPI_HS_REQ: begin
          if (core_int_ack) begin
            hs_q <= npi_pkg::NPI_HS_IDLE; // R7
          end
        end
      endcase
    end
  end

  // request outranks every process queue in the core
  assign core_int_req = (hs_q == npi_pkg::NPI_HS_REQ); // R3 R7
  assign core_int_level = req_lvl_q;
  // top of the level's own save area in the handler workspace
  assign handler_workspace_ptr = req_ptr_q; // R8 R9 R16
  assign active_levels = active_q;
  assign handler_busy = exec_busy;

endmodule

// ---- sim/npi_ctrl_props.sv ----
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
module npi_ctrl_props #(
  parameter int LEVELS = npi_pkg::NPI_LEVELS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic core_int_req,
  input wire logic [2:0] core_int_level,
  input wire logic [31:0] handler_workspace_ptr,
  input wire logic core_int_ack,
  input wire logic core_int_return,
  input wire logic [LEVELS-1:0] active_levels,
  input wire logic handler_busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic taken;
  // request accepted by the core at this edge
  assign taken = core_int_req && core_int_ack;
  ////////////////////////////////////////////////////////////
  property p_ack_drop;
    taken |=> !core_int_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("request still up after ack");
  property p_hold;
    core_int_req && !core_int_ack |=> core_int_req && $stable(core_int_level)
      && $stable(handler_workspace_ptr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_ack_set;
    taken && !core_int_return |=> active_levels ==
      ($past(active_levels) | (LEVELS'(1) << $past(core_int_level)));
  endproperty
  a_ack_set: assert property (p_ack_set)
    else $error("active level not recorded at ack");
  property p_keep;
    !taken && !core_int_return |=> $stable(active_levels);
  endproperty
  a_keep: assert property (p_keep)
    else $error("active levels changed without cause");
  property p_ret;
    core_int_return && !taken && active_levels != '0 |=>
      (($past(active_levels) ^ active_levels) > active_levels)
      && $countones($past(active_levels) ^ active_levels) == 1
      && (active_levels & ~$past(active_levels)) == '0;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not clear the top active level");
  property p_above;
    core_int_req |-> (active_levels >> core_int_level) == '0;
  endproperty
  a_above: assert property (p_above)
    else $error("request not above executing level");
  property p_ptr;
    core_int_req |-> handler_workspace_ptr[1:0] == 2'h0 && core_int_level < LEVELS;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("bad level or pointer with request");
  property p_busy;
    handler_busy == (active_levels != '0);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy flag disagrees with active levels");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err)
    else $error("error flag outside access phase");
endmodule

bind npi_ctrl npi_ctrl_props #(.LEVELS(LEVELS)) u_npi_ctrl_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
  .core_int_req(core_int_req), .core_int_level(core_int_level),
  .handler_workspace_ptr(handler_workspace_ptr), .core_int_ack(core_int_ack),
  .core_int_return(core_int_return), .active_levels(active_levels),
  .handler_busy(handler_busy));

// ---- sim/npi_core_model.sv ----
// processor core model: acknowledges requests and returns from handlers
`timescale 1ns/1ps
module npi_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_int_req,
  input wire logic [3:0] ack_dly,
  input wire logic auto_ret,
  input wire logic ret_go,
  output logic core_int_ack,
  output logic core_int_return
);
  logic [3:0] wait_q;
  logic [3:0] ret_q;
  logic [2:0] depth_q;
  logic fire;
  ////////////////////////////////////////////////////////////
  // acknowledge after a chosen wait, one cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      core_int_ack <= 1'b0;
    end else if (core_int_req && !core_int_ack && wait_q >= ack_dly) begin
      core_int_ack <= 1'b1;
      wait_q <= 4'h0;
    end else begin
      core_int_ack <= 1'b0;
      wait_q <= (core_int_req && !core_int_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
  // handler finishes on command or after a short run
  assign fire = !core_int_return && depth_q != 3'h0 &&
    (ret_go || (auto_ret && ret_q == 4'h6));
  // nesting depth and completion pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_q <= 3'h0;
      ret_q <= 4'h0;
      core_int_return <= 1'b0;
    end else begin
      core_int_return <= fire;
      ret_q <= (depth_q != 3'h0 && !fire) ? ret_q + 4'h1 : 4'h0;
      depth_q <= depth_q + {2'h0, core_int_req & core_int_ack} - {2'h0, fire};
    end
  end
endmodule

// ---- sim/test_nested_priority_interrupt_ctrl.sv ----
// self-checking bench for the nested priority interrupt controller
`timescale 1ns/1ps
module test_nested_priority_interrupt_ctrl;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, core_int_req, core_int_ack, core_int_return, handler_busy;
  logic [1:0] ext_irq_pin = 2'h0;
  logic [2:0] periph_irq = 3'h0;
  logic [2:0] core_int_level, last_lvl;
  logic [31:0] handler_workspace_ptr, last_ptr, rdat;
  logic [4:0] active_levels;
  logic [3:0] ack_dly = 4'h1;
  logic auto_ret = 1'b0;
  logic ret_go = 1'b0;
  logic rerr;
  int error_cnt = 0;
  int compares = 0;
  int ack_cnt = 0;
  int n_exp [8] = '{0, 2, 2, 1, 1, 1, 0, 0};
  int got;
  ////////////////////////////////////////////////////////////
  // clock, design and core model
  always #25 pclk = ~pclk;
  npi_ctrl u_npi_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .periph_irq(periph_irq),
    .core_int_req(core_int_req), .core_int_level(core_int_level),
    .handler_workspace_ptr(handler_workspace_ptr), .core_int_ack(core_int_ack),
    .core_int_return(core_int_return), .active_levels(active_levels),
    .handler_busy(handler_busy));
  npi_core_model u_npi_core_model (.pclk(pclk), .presetn(presetn),
    .core_int_req(core_int_req), .ack_dly(ack_dly), .auto_ret(auto_ret),
    .ret_go(ret_go), .core_int_ack(core_int_ack), .core_int_return(core_int_return));
  // record every accepted request
  always @(posedge pclk) begin
    if (core_int_req && core_int_ack) begin
      ack_cnt <= ack_cnt + 1;
      last_lvl <= core_int_level;
      last_ptr <= handler_workspace_ptr;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // count acks over a window, check level and pointer of the last
  task automatic acks(input int cyc, input int n, input logic [2:0] l);
    int base;
    base = ack_cnt;
    repeat (cyc) @(posedge pclk);
    chk(ack_cnt - base, n);
    if (n > 0) begin
      chk(last_lvl, l);
      chk(last_ptr, 32'h0000_1000 + {l, 8'h00});
    end
  endtask
  task automatic ret();
    ret_go <= 1'b1;
    @(posedge pclk);
    ret_go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h0C0, npi_pkg::NPI_MASK_RESET);
    rd(12'h088, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(rerr, 1'b1);
    for (int n = 0; n < 5; n++) begin
      wr(12'h000 + 12'(4 * n), 32'h0000_1003 + 32'(n * 256));
    end
    rd(12'h010, 32'h0000_1400);
    wr(12'h084, 32'h4);
    wr(12'h0C0, 32'h4);
    acks(20, 0, 3'h0);
    rd(12'h080, 32'h4);
    wr(12'h0C0, 32'h10004);
    acks(10, 1, 3'h2);
    chk(active_levels, 5'h04);
    rd(12'h080, 32'h0);
    rd(12'h088, 32'h1204);
    wr(12'h084, 32'h2);
    wr(12'h0C0, 32'h10016);
    acks(20, 0, 3'h0);
    wr(12'h050, 32'h3);
    ext_irq_pin <= 2'b10;
    acks(20, 1, 3'h4);
    ext_irq_pin <= 2'b00;
    chk(active_levels, 5'h14);
    ret();
    chk(active_levels, 5'h04);
    ret();
    acks(20, 1, 3'h1);
    ret();
    wr(12'h0C0, 32'h10003);
    wr(12'h084, 32'h3);
    acks(10, 1, 3'h1);
    acks(20, 0, 3'h0);
    ret();
    acks(20, 1, 3'h0);
    ret();
    chk(active_levels, 5'h00);
    auto_ret <= 1'b1;
    wr(12'h0C0, 32'h10001);
    for (int m = 0; m < 8; m++) begin
      wr(12'h040, 32'h0);
      periph_irq[0] <= (m == 2 || m == 4);
      wr(12'h040, 32'(m));
      acks(10, 0, 3'h0);
      got = ack_cnt;
      periph_irq[0] <= !(m == 2 || m == 4);
      repeat (60) @(posedge pclk);
      got = ack_cnt - got;
      if (n_exp[m] == 2) begin
        chk(got > 1, 1'b1);
      end else begin
        chk(got, n_exp[m]);
      end
      periph_irq[0] <= (m == 2 || m == 4);
      repeat (30) @(posedge pclk);
    end
    final_report();
  end
endmodule
